// ==== core/sbcspi_device.sv ====
// Device end of the serial command port: framing, command checks, registers, interrupt
`timescale 1ns/100ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module sbcspi_device
   import sbcspi_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Serial link
   sbcspi_link_if.dev link,
   // Device pins
   input wire logic wake_pin_i,
   input wire logic dev_mode_i,
   // Accepted command
   output logic [2:0] mode_o,
   output logic [WORD_W-1:0] ctrl_word_o,
   output logic ctrl_valid_o,
   output logic wd_kick_o,
   // Interrupt
   output logic int_o
);

   // ----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------------------------------
   logic sel_n_s, sclk_s, sin_s, wake_s;
   logic sel_n_p_q, sclk_p_q, wake_p_q;
   logic active, sel_fall, sel_rise, clk_rise, clk_fall;

   sbcspi_sync #(.W(4), .RST(4'b0001)) u_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .d_i({wake_pin_i, link.serial_in, link.sclk, link.select_n}),
      .q_o({wake_s, sin_s, sclk_s, sel_n_s})
   );

   // Previous values for edge finding
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sel_n_p_q <= 1'b1;
         sclk_p_q <= 1'b0;
         wake_p_q <= 1'b0;
      end else begin
         sel_n_p_q <= sel_n_s;
         sclk_p_q <= sclk_s;
         wake_p_q <= wake_s;
      end
   end

   assign active = ~sel_n_s;
   assign sel_fall = ~sel_n_s & sel_n_p_q;
   assign sel_rise = sel_n_s & ~sel_n_p_q;
   assign clk_rise = active & sclk_s & ~sclk_p_q;
   assign clk_fall = active & ~sclk_s & sclk_p_q;

   // ----------------------------------------------------------------
   // Receive shift register and clock counter
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] sh_in_q;
   logic [CNT_W-1:0] cnt_q;
   logic seen_q;

   // Shift serial_in on each falling clock of a selected frame
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sh_in_q <= WORD_RST;
         cnt_q <= '0;
         seen_q <= 1'b0;
      end else if (sel_fall) begin
         cnt_q <= '0;
         seen_q <= 1'b0;
      end else if (clk_fall) begin
         sh_in_q <= {sh_in_q[WORD_W-2:0], sin_s};
         cnt_q <= cnt_q + 1'b1;
         seen_q <= 1'b1;
      end
   end

   // Received fields
   logic [2:0] rx_mode, rx_cfg, ro_mode, ro_cfg;
   logic [DATA_W-1:0] rx_data;
   logic rx_wd, frame_ok, mode_ok, cmd_bad, accept;

   assign rx_mode = sh_in_q[MODE_HI:MODE_LO];
   assign rx_cfg = sh_in_q[CFG_HI:CFG_LO];
   assign rx_data = sh_in_q[DATA_W-1:0];
   assign rx_wd = sh_in_q[WD_BIT];
   // Mode and cfg fields as they complete, seen at the seventh falling clock
   assign ro_mode = sh_in_q[4:2];
   assign ro_cfg = {sh_in_q[1:0], sin_s};

   // ----------------------------------------------------------------
   // Command checking
   // ----------------------------------------------------------------
   logic [2:0] mode_q;

   // Mode transitions the state machine allows
   function automatic logic mode_allowed(input logic [2:0] cur, input logic [2:0] req, input logic dev);
      logic ok;
      ok = 1'b1;
      unique case (req)
         MODE_NONE: ok = 1'b0;
         MODE_RESTART: ok = (cur == MODE_SWFLASH);
         MODE_SWFLASH: ok = (cur != MODE_STOP);
         MODE_FAILSAFE: ok = dev;
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction

   assign frame_ok = seen_q && (cnt_q == '0);
   assign mode_ok = mode_allowed(mode_q, rx_mode, dev_mode_i);
   assign cmd_bad = ~frame_ok | ~mode_ok;
   assign accept = sel_rise & ~cmd_bad;

   // ----------------------------------------------------------------
   // Register file and interrupt
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] regs_q [8];
   logic [EV_W-1:0] status_q, irq_en_q, ev, clr;
   logic wr_en;

   assign wr_en = accept && (rx_mode != MODE_RDONLY);

   // Register contents as read back over the link
   function automatic logic [DATA_W-1:0] rd_data(input logic [2:0] cfg);
      logic [DATA_W-1:0] d;
      d = '0;
      if (cfg == CFG_COMM) begin
         d[CLR_LO +: EV_W] = status_q;
         d[EN_LO +: EV_W] = irq_en_q;
      end else if (cfg != CFG_RSVD) begin
         d = regs_q[cfg];
      end
      return d;
   endfunction

   // Write the selected configuration register
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 8; i++) begin
            regs_q[i] <= REG_RST;
         end
         irq_en_q <= IRQ_EN_RST;
      end else if (wr_en) begin
         if (rx_cfg == CFG_COMM) begin
            irq_en_q <= rx_data[EN_LO +: EV_W];
         end else if (rx_cfg != CFG_RSVD) begin
            regs_q[rx_cfg] <= rx_data;
         end
      end
   end

   assign ev[EV_SPI_FAIL] = sel_rise & cmd_bad;
   assign ev[EV_FRAME] = sel_rise & ~frame_ok;
   assign ev[EV_WAKE] = wake_s ^ wake_p_q;
   assign clr = (wr_en && rx_cfg == CFG_COMM) ? rx_data[CLR_LO +: EV_W] : '0;

   // Sticky status, an event wins over its own clear
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clr) | ev;
      end
   end

   assign int_o = |(status_q & irq_en_q);

   // ----------------------------------------------------------------
   // Frame outcome: control word, mode, watchdog, error memory
   // ----------------------------------------------------------------
   logic fe_pend_q, repeat_q, wd_last_q;

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         mode_q <= MODE_NONE;
         ctrl_word_o <= WORD_RST;
         ctrl_valid_o <= 1'b0;
         wd_kick_o <= 1'b0;
         wd_last_q <= 1'b0;
         fe_pend_q <= 1'b0;
         repeat_q <= 1'b0;
      end else begin
         ctrl_valid_o <= wr_en;
         wd_kick_o <= accept && (rx_wd != wd_last_q);
         if (sel_rise) begin
            fe_pend_q <= ~frame_ok;
            repeat_q <= cmd_bad;
         end
         if (accept) begin
            wd_last_q <= rx_wd;
         end
         if (wr_en) begin
            mode_q <= rx_mode;
            ctrl_word_o <= sh_in_q;
         end
      end
   end

   assign mode_o = mode_q;

   // ----------------------------------------------------------------
   // Transmit word and data-out pin
   // ----------------------------------------------------------------
   logic [WORD_W-1:0] out_word_q, prev_q, word_new;
   logic [CNT_W-1:0] out_idx_q;
   logic sout_q, oe_q;

   always_comb begin
      word_new = {fe_pend_q, mode_q, rx_cfg, wake_s, rd_data(rx_cfg)};
   end

   // Load at frame start, patch read data mid-frame, step on rising clocks
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         out_word_q <= WORD_RST;
         prev_q <= WORD_RST;
         out_idx_q <= CNT_W'(WORD_W - 1);
      end else if (sel_fall) begin
         out_idx_q <= CNT_W'(WORD_W - 1);
         if (repeat_q) begin
            out_word_q <= {fe_pend_q, prev_q[WORD_W-2:0]};
         end else begin
            out_word_q <= word_new;
         end
      end else if (sel_rise) begin
         prev_q <= out_word_q;
      end else if (clk_rise && seen_q) begin // First bit stands through the first rise
         out_idx_q <= out_idx_q - 1'b1;
      end else if (clk_fall && cnt_q == CNT_W'(RO_LOAD_CNT - 1) && ro_mode == MODE_RDONLY) begin
         out_word_q[DATA_W-1:0] <= rd_data(ro_cfg);
      end
   end

   // Pin drivers from flops, released while deselected
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         sout_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         sout_q <= out_word_q[out_idx_q];
         oe_q <= active;
      end
   end

   assign link.serial_out = sout_q;
   assign link.serial_out_oe = oe_q;

endmodule

// ==== core/sbcspi_host.sv ====
// Microcontroller end: register-driven master that runs frames on the serial link
`timescale 1ns/100ps
module sbcspi_host
   import sbcspi_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [WORD_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [WORD_W-1:0] rdata_o,
   // Interrupt
   output logic int_o,
   // Serial link
   sbcspi_link_if.host link
);

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} sbcspi_hst_e;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   sbcspi_hst_e st_q;
   logic [WORD_W-1:0] tx_q, rx_q, sh_tx_q, sh_rx_q;
   logic [NB_W-1:0] left_q;
   logic [TMR_W-1:0] tmr_q;
   logic [HEV_W-1:0] status_q, mask_q, ev, clr;
   logic sel_n_q, sclk_q, mosi_q, miso_s, start, tmr_done, finish;

   sbcspi_sync #(.W(1), .RST(1'b1)) u_sync (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .d_i(link.miso_line),
      .q_o(miso_s)
   );

   assign start = wr_i && addr_i == ADDR_CTRL && st_q == H_IDLE;
   assign tmr_done = (tmr_q == '0);
   assign finish = st_q == H_LOW && tmr_done && left_q == '0;

   // Word to send and mask written by software
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         tx_q <= WORD_RST;
         mask_q <= '0;
      end else if (wr_i) begin
         if (addr_i == ADDR_TX) begin
            tx_q <= wdata_i;
         end
         if (addr_i == ADDR_MASK) begin
            mask_q <= wdata_i[HEV_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame sequencer: select, half-period clock, shift in and out
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         st_q <= H_IDLE;
         sel_n_q <= 1'b1;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         sh_tx_q <= WORD_RST;
         sh_rx_q <= WORD_RST;
         rx_q <= WORD_RST;
         left_q <= '0;
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_done ? '0 : tmr_q - 1'b1;
         unique case (st_q)
            H_IDLE: begin
               if (start) begin
                  sel_n_q <= 1'b0;
                  mosi_q <= tx_q[WD_BIT];
                  sh_tx_q <= tx_q;
                  left_q <= (wdata_i[NB_W-1:0] == '0) ? NB_W'(WORD_W) : wdata_i[NB_W-1:0];
                  tmr_q <= TMR_W'(SCLK_HALF_CYC - 1);
                  st_q <= H_LOW;
               end
            end
            H_LOW: begin
               if (tmr_done) begin
                  tmr_q <= TMR_W'(SCLK_HALF_CYC - 1);
                  if (left_q == '0) begin
                     sel_n_q <= 1'b1;
                     rx_q <= sh_rx_q;
                     tmr_q <= TMR_W'(GAP_CYC - 1);
                     st_q <= H_GAP;
                  end else begin
                     sclk_q <= 1'b1;
                     mosi_q <= sh_tx_q[WORD_W-1];
                     sh_tx_q <= {sh_tx_q[WORD_W-2:0], 1'b0};
                     st_q <= H_HIGH;
                  end
               end
            end
            H_HIGH: begin
               if (tmr_done) begin
                  sclk_q <= 1'b0;
                  sh_rx_q <= {sh_rx_q[WORD_W-2:0], miso_s};
                  left_q <= left_q - 1'b1;
                  tmr_q <= TMR_W'(SCLK_HALF_CYC - 1);
                  st_q <= H_LOW;
               end
            end
            H_GAP: begin
               if (tmr_done) begin
                  st_q <= H_IDLE;
               end
            end
         endcase
      end
   end

   assign link.select_n = sel_n_q;
   assign link.sclk = sclk_q;
   assign link.serial_in = mosi_q;

   // ----------------------------------------------------------------
   // Status, interrupt and read port
   // ----------------------------------------------------------------
   assign ev[HEV_DONE] = finish;
   assign ev[HEV_FERR] = finish & sh_rx_q[FE_BIT];
   assign clr = (wr_i && addr_i == ADDR_STAT) ? wdata_i[HEV_W-1:0] : '0;

   // Sticky events, set wins over clear
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q & ~clr) | ev;
      end
   end

   assign int_o = |(status_q & mask_q);

   // Read data in the cycle after the strobe only
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= '0;
         if (rd_i) begin
            unique case (addr_i)
               ADDR_TX: rdata_o <= tx_q;
               ADDR_RX: rdata_o <= rx_q;
               ADDR_STAT: rdata_o <= WORD_W'({(st_q != H_IDLE), 6'h00, status_q});
               ADDR_MASK: rdata_o <= WORD_W'(mask_q);
               default: rdata_o <= '0;
            endcase
         end
      end
   end

endmodule

// ==== core/sbcspi_link_if.sv ====
// Link between the microcontroller end and the device end of the serial port
`timescale 1ns/100ps
interface sbcspi_link_if;
   logic select_n;
   logic sclk;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic miso_line;

   // Shared data-out line with a pull-up when nobody drives it
   assign miso_line = serial_out_oe ? serial_out : 1'b1;

   modport dev (input select_n, input sclk, input serial_in, output serial_out, output serial_out_oe);
   modport host (output select_n, output sclk, output serial_in, input miso_line);
endinterface

// ==== core/sbcspi_pkg.sv ====
// Shared constants for the serial command port: word layout, codes, timing, host map
package sbcspi_pkg;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int CNT_W = 4;
   localparam int DATA_W = 8;
   localparam int WD_BIT = 15;      // Input: watchdog_trigger_bit
   localparam int MODE_HI = 14;     // Input and output: mode_select_field
   localparam int MODE_LO = 12;
   localparam int CFG_HI = 11;      // Input and output: cfg_select_field
   localparam int CFG_LO = 9;
   localparam int FE_BIT = 15;      // Output: frame_error_flag
   localparam int WAKE_BIT = 8;     // Output: wake_pin_level
   localparam int RO_LOAD_CNT = 7;  // Bits received once mode and cfg fields are complete

   // ----------------------------------------------------------------
   // Mode and configuration codes
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_NONE = 3'h0;
   localparam logic [2:0] MODE_RESTART = 3'h1;
   localparam logic [2:0] MODE_SWFLASH = 3'h2;
   localparam logic [2:0] MODE_NORMAL = 3'h3;
   localparam logic [2:0] MODE_SLEEP = 3'h4;
   localparam logic [2:0] MODE_STOP = 3'h5;
   localparam logic [2:0] MODE_FAILSAFE = 3'h6;
   localparam logic [2:0] MODE_RDONLY = 3'h7;
   localparam logic [2:0] CFG_COMM = 3'h2;
   localparam logic [2:0] CFG_RSVD = 3'h3;

   // ----------------------------------------------------------------
   // Device interrupt layout (inside the communication failure register)
   // ----------------------------------------------------------------
   localparam int EV_W = 3;
   localparam int EV_SPI_FAIL = 0;
   localparam int EV_FRAME = 1;
   localparam int EV_WAKE = 2;
   localparam int EN_LO = 0;         // Enable bits [2:0]
   localparam int CLR_LO = 4;        // Write-one-clear bits [6:4], status reads back here
   localparam logic [EV_W-1:0] IRQ_EN_RST = 3'h7;
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 5;
   localparam int SCLK_NS = 160;
   localparam int SCLK_HALF_CYC = SCLK_NS / (2 * CLK_NS);
   localparam int TMR_W = 5;
   localparam int GAP_CYC = 2 * SCLK_HALF_CYC;

   // ----------------------------------------------------------------
   // Host register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_TX = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_RX = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h10;
   localparam int NB_W = 5;          // CTRL [4:0]: clocks per frame, 0 means 16
   localparam int HEV_W = 2;
   localparam int HEV_DONE = 0;
   localparam int HEV_FERR = 1;
   localparam int BUSY_BIT = 8;

endpackage

// ==== core/sbcspi_sync.sv ====
// Two flip-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/100ps
module sbcspi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         meta_q <= RST;
         q_o <= RST;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule

// ==== sim/sbc_spi_command_port_tb_top.sv ====
// Testbench joining the host end and the device end of the serial command port
`timescale 1ns/100ps
module sbc_spi_command_port_tb_top;
   import sbcspi_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   localparam logic [26:0] TM = {MODE_NORMAL, MODE_SLEEP, MODE_FAILSAFE, MODE_FAILSAFE, MODE_SWFLASH,
      MODE_STOP, MODE_RESTART, MODE_SWFLASH, MODE_RESTART};
   localparam logic [8:0] TOK = 9'h1ce;
   localparam logic [8:0] TDV = 9'h040;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic wr = 1'b0, rd = 1'b0, wake = 1'b0, devm = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [WORD_W-1:0] wdata = '0, rdata, cw, rx, rxb, st;
   logic [2:0] mode, cur;
   logic vld, kick, hint, dint, wd;
   int n_fail = 0, checks = 0, nv = 0, nk = 0, k = 0, cyc = 0;
   sbcspi_link_if lk();
   sbcspi_host u_sbcspi_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .int_o(hint), .link(lk));
   sbcspi_device u_sbcspi_device (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(lk), .wake_pin_i(wake),
      .dev_mode_i(devm), .mode_o(mode), .ctrl_word_o(cw), .ctrl_valid_o(vld), .wd_kick_o(kick), .int_o(dint));
   sbcspi_assertions u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .select_n(lk.select_n), .sclk(lk.sclk),
      .serial_in(lk.serial_in), .serial_out(lk.serial_out), .serial_out_oe(lk.serial_out_oe),
      .miso_line(lk.miso_line));

   // Clock
   initial forever #2.5 mclk_i = ~mclk_i;

   // Pulse counters and run limit
   always @(negedge mclk_i) begin
      nv += (vld === 1'b1);
      nk += (kick === 1'b1);
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wrt(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task automatic rdt(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      @(negedge mclk_i);
      d = rdata;
   endtask
   // One full frame: clear host status, load word, start, wait for busy to end, fetch reply
   task automatic frame(input logic [15:0] w, input logic [4:0] nb);
      int n;
      logic b;
      n = 0;
      b = 1'b0;
      wrt(ADDR_STAT, 16'h0003);
      wrt(ADDR_TX, w);
      wrt(ADDR_CTRL, {11'h000, nb});
      do begin
         rdt(ADDR_STAT, st);
         b |= st[BUSY_BIT];
         n++;
      end while ((!b || st[BUSY_BIT] !== 1'b0) && n < 500);
      if (n >= 500) begin
         n_fail++;
         $display("[FAIL] %0t frame never finished", $time);
      end
      rdt(ADDR_RX, rx);
      repeat (8) @(posedge mclk_i);
   endtask
   function automatic logic [15:0] cmd(input logic w, input logic [2:0] m, input logic [7:0] d);
      return {w, m, CFG_COMM, 1'b0, d};
   endfunction
   task automatic results();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge mclk_i);
      rstn_i <= 1'b1;
      chk(mode, MODE_NONE);
      chk(cw, WORD_RST);
      chk(dint, 1'b0);
      rdt(8'h14, st);
      chk(st, 16'h0000);
      wrt(ADDR_MASK, 16'hffff);
      rdt(ADDR_MASK, st);
      chk(st, 16'h0003);
      wrt(ADDR_MASK, 16'h0001);
      // Plain write, first watchdog one
      frame(cmd(1'b1, MODE_NORMAL, 8'h07), 5'h00);
      chk(rx[FE_BIT], 1'b0);
      chk(rx[WAKE_BIT], 1'b0);
      chk(mode, MODE_NORMAL);
      chk(cw, cmd(1'b1, MODE_NORMAL, 8'h07));
      chk(nv, 1);
      chk(nk, 1);
      chk(hint, 1'b1);
      // Wake event, then read-only access to the status register
      wrt(ADDR_MASK, 16'h0000);
      @(posedge mclk_i);
      wake <= 1'b1;
      repeat (8) @(posedge mclk_i);
      chk(dint, 1'b1);
      frame(cmd(1'b0, MODE_RDONLY, 8'h00), 5'h00);
      chk(rx[7:0], 8'h47);
      chk(rx[WAKE_BIT], 1'b1);
      chk(mode, MODE_NORMAL);
      chk(cw, cmd(1'b1, MODE_NORMAL, 8'h07));
      chk(nk, 2);
      chk(hint, 1'b0);
      rdt(ADDR_STAT, st);
      chk(st[1:0], 2'h1);
      frame(cmd(1'b1, MODE_NORMAL, 8'h77), 5'h00);
      chk(dint, 1'b0);
      chk(cw, cmd(1'b1, MODE_NORMAL, 8'h77));
      // Mode code zero, then the reply repeats
      frame(cmd(1'b0, MODE_NONE, 8'h07), 5'h00);
      rxb = rx;
      chk(mode, MODE_NORMAL);
      chk(cw, cmd(1'b1, MODE_NORMAL, 8'h77));
      chk(dint, 1'b1);
      chk(nk, 3);
      frame(cmd(1'b0, MODE_NORMAL, 8'h17), 5'h00);
      chk(rx, {1'b0, rxb[14:0]});
      chk(nk, 4);
      // Mode changes, allowed and forbidden
      k = 4;
      cur = MODE_NORMAL;
      wd = 1'b0;
      for (int i = 0; i < 9; i++) begin
         @(posedge mclk_i);
         devm <= TDV[i];
         frame(cmd(~wd, TM[3*i +: 3], 8'h17), 5'h00);
         chk(rx[14:12], cur);
         if (TOK[i]) begin
            cur = TM[3*i +: 3];
            wd = ~wd;
            k++;
         end
         chk(mode, cur);
         chk(dint, !TOK[i]);
         chk(nk, k);
      end
      // Short frame, then the error flag leads the next reply
      frame(cmd(~wd, MODE_STOP, 8'h17), 5'h08);
      chk(mode, cur);
      chk(nk, k);
      chk(dint, 1'b1);
      frame(cmd(~wd, MODE_NORMAL, 8'h77), 5'h00);
      chk(rx[FE_BIT], 1'b1);
      rdt(ADDR_STAT, st);
      chk(st[HEV_FERR], 1'b1);
      chk(dint, 1'b0);
      results();
   end
endmodule

// ==== sim/sbcspi_assertions.sv ====
// Checker for the serial link between the host end and the device end
`timescale 1ns/100ps
module sbcspi_assertions (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Link signals
   input wire logic select_n,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic miso_line
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic sclk_q, sel_q, first_q, bad_q, ok_q;
   logic [4:0] since_q;
   logic [3:0] desel_q;
   logic [5:0] nf_q;
   logic [2:0] cfg_q;
   logic [15:0] in_q, out_q;
   wire rise = sclk & ~sclk_q;
   wire fall = ~sclk & sclk_q;
   wire srise = select_n & ~sel_q;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   // Edge history and distance to the last rising clock or select edge
   always_ff @(posedge mclk_i) begin
      sclk_q <= rstn_i & sclk;
      sel_q <= ~rstn_i | select_n;
      since_q <= (!rstn_i || rise || select_n != sel_q) ? 5'h00 : since_q + {4'h0, since_q != 5'h1f};
      desel_q <= (!rstn_i || !select_n) ? 4'h0 : desel_q + {3'h0, desel_q != 4'hf};
   end

   // Falls per frame, words seen on both data lines, outcome of the last frame
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         nf_q <= 6'h00;
         first_q <= 1'b0;
         bad_q <= 1'b0;
         ok_q <= 1'b0;
         cfg_q <= 3'h0;
      end else if (srise) begin
         nf_q <= 6'h00;
         bad_q <= nf_q[3:0] != 4'h0 || nf_q == 6'h00;
         ok_q <= nf_q == 6'h10 && in_q[14:12] != 3'h0;
         cfg_q <= in_q[11:9];
      end else if (!select_n) begin
         first_q <= sel_q | (first_q & ~rise);
         if (fall) begin
            nf_q <= nf_q + 6'h01;
            in_q <= {in_q[14:0], serial_in};
            out_q <= {out_q[14:0], miso_line};
         end
      end
   end

   a_oe_release: assert property ($rose(select_n) |-> ##[1:8] !serial_out_oe) else $error("oe held");
   a_oe_enable: assert property ($fell(select_n) |-> ##[1:8] serial_out_oe) else $error("oe late");
   a_oe_only_sel: assert property (serial_out_oe |-> desel_q < 4'h8) else $error("oe unselected");
   a_out_after_rise: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
      |-> since_q < 5'h09) else $error("out moved late");
   a_oe_at_rise: assert property (rise && !select_n |-> serial_out_oe) else $error("no drive at rise");
   a_stable_fall: assert property (fall && !select_n |-> $stable(serial_out)) else $error("out moved");
   a_fe_lead: assert property (rise && first_q && !select_n |-> serial_out == bad_q)
      else $error("frame error flag wrong");
   a_cfg_echo: assert property (srise && nf_q == 6'h10 && ok_q |-> out_q[11:9] == cfg_q)
      else $error("cfg echo wrong");
endmodule
